// ===== rmpu_pkg.sv
`default_nettype none
package rmpu_pkg;
    // region address granularity: low bits forced per direction
    localparam int unsigned          GRAN_BITS     = 5;
    localparam logic [GRAN_BITS-1:0] GRAN_ZERO     = 5'h00;
    localparam logic [GRAN_BITS-1:0] GRAN_ONES     = 5'h1F;
    // master numbering
    localparam int unsigned          MASTER_W      = 3;
    localparam int unsigned          NUM_MASTERS   = 8;
    localparam logic [MASTER_W-1:0]  CORE_MASTER   = 3'h0;
    localparam logic [MASTER_W-1:0]  DEBUG_MASTER  = 3'h1;
    localparam logic [MASTER_W-1:0]  LAST_FULL_MASTER = 3'h3;
    // rights word: full format [4:3] supervisor code, [2] r, [1] w, [0] x
    // reduced format uses [1] r, [0] w only
    localparam int unsigned          RIGHTS_W      = 5;
    localparam logic [RIGHTS_W-1:0]  RIGHTS_FULL   = 5'h07;
    localparam logic [RIGHTS_W-1:0]  RIGHTS_NONE   = 5'h00;
    localparam logic [RIGHTS_W-1:0]  REDUCED_MASK  = 5'h03;
    localparam int unsigned          USR_R_BIT     = 2;
    localparam int unsigned          USR_W_BIT     = 1;
    localparam int unsigned          USR_X_BIT     = 0;
    localparam int unsigned          RED_R_BIT     = 1;
    localparam int unsigned          RED_W_BIT     = 0;
    localparam int unsigned          SUP_LO_BIT    = 3;
    localparam int unsigned          SUP_HI_BIT    = 4;
    typedef enum logic [1:0] {
        SUP_RWX  = 2'h0,
        SUP_RX   = 2'h1,
        SUP_RW   = 2'h2,
        SUP_USER = 2'h3
    } rmpu_sup_t;
    // configuration write selector
    typedef enum logic [1:0] {
        FIELD_BEGIN  = 2'h0,
        FIELD_LAST   = 2'h1,
        FIELD_RIGHTS = 2'h2,
        FIELD_ENABLE = 2'h3
    } rmpu_field_t;
    // captured violation cause
    typedef enum logic [1:0] {
        CAUSE_NO_HIT  = 2'h0,
        CAUSE_SINGLE  = 2'h1,
        CAUSE_OVERLAP = 2'h2
    } rmpu_cause_t;
    // region count codes
    localparam logic [1:0] REGIONS_8  = 2'h0;
    localparam logic [1:0] REGIONS_12 = 2'h1;
    localparam logic [1:0] REGIONS_16 = 2'h2;
endpackage
`default_nettype wire

// ===== rmpu_region_check.sv
`timescale 1ns/100ps
`default_nettype none
module rmpu_region_check
    import rmpu_pkg::*;
#(
    parameter int unsigned ADDR_W = 32
) (
    // region descriptor
    input  wire logic                    region_on,
    input  wire logic [ADDR_W-1:0]       region_begin_address,
    input  wire logic [ADDR_W-1:0]       region_last_address,
    input  wire logic [RIGHTS_W-1:0]     rights,
    // access
    input  wire logic [MASTER_W-1:0]     master,
    input  wire logic                    super_mode,
    input  wire logic                    instr,
    input  wire logic                    write,
    input  wire logic [ADDR_W-1:0]       addr,
    // result
    output logic                         hit,
    output logic                         allow
);
    logic r_ok;
    logic w_ok;
    logic x_ok;

    // a disabled region never hits, so it takes no part in checks
    assign hit = region_on && (addr >= region_begin_address)
                 && (addr <= region_last_address); // R06

    always_comb begin
        if (master > LAST_FULL_MASTER) begin // R08
            // reduced format has no execute bit: fetches count as reads
            r_ok = rights[RED_R_BIT];
            w_ok = rights[RED_W_BIT];
            x_ok = rights[RED_R_BIT];
        end else begin
            r_ok = rights[USR_R_BIT]; // R11
            w_ok = rights[USR_W_BIT];
            x_ok = rights[USR_X_BIT];
            if (super_mode) begin
                case (rmpu_sup_t'(rights[SUP_HI_BIT:SUP_LO_BIT])) // R11
                    SUP_RWX: begin
                        r_ok = 1'b1;
                        w_ok = 1'b1;
                        x_ok = 1'b1;
                    end
                    SUP_RX: begin
                        r_ok = 1'b1;
                        w_ok = 1'b0;
                        x_ok = 1'b1;
                    end
                    SUP_RW: begin
                        r_ok = 1'b1;
                        w_ok = 1'b1;
                        x_ok = 1'b0;
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    assign allow = hit && (write ? w_ok : (instr ? x_ok : r_ok));
endmodule // rmpu_region_check
`default_nettype wire

// ===== region_memory_protection_unit.sv
// How it works
// R01 - region begin address low five bits always read as zero
// R02 - region last address low five bits always read as ones
// R03 - core writes cannot change region zero bounds or debugger rights
// R04 - core may still write region zero rights of non-debugger masters
// R05 - global enable turns all checking on or off
// R06 - per-region enable; disabled regions never take part in checks
// R07 - each master's rights set independently in every region
// R08 - masters 0-3 full format, masters 4-7 read/write only
// R09 - per slave port sticky error flag set on violation
// R10 - per port capture of master, mode, direction, cause and address
// R11 - supervisor code rwx/rx/rw/user; user has separate r, w, x bits
// R12 - debugger always keeps full access through region zero; the debugger's own writes to region zero can still remove it
// R13 - read-only identification of revision, ports and region count
// R14 - accesses with no granting enabled region are blocked and captured
// R15 - masters present number, mode, fetch flag, direction and address
`timescale 1ns/100ps
`default_nettype none
module region_memory_protection_unit
    import rmpu_pkg::*;
#(
    parameter int unsigned ADDR_W    = 32,
    parameter int unsigned REGIONS   = 8,
    parameter int unsigned PORTS     = 5,
    parameter logic [7:0]  REVISION  = 8'h01 // arbitrary value
) (
    // clock and reset
    input  wire logic                        clk,
    input  wire logic                        reset,
    // control
    input  wire logic                        prot_enable,
    // configuration write
    input  wire logic                        cfg_write,
    input  wire logic [MASTER_W-1:0]         cfg_src_master,
    input  wire logic [$clog2(REGIONS)-1:0]  cfg_region,
    input  wire rmpu_field_t                 cfg_field,
    input  wire logic [MASTER_W-1:0]         cfg_master,
    input  wire logic [ADDR_W-1:0]           cfg_wdata,
    // access checks, one per slave port
    input  wire logic [PORTS-1:0]            acc_valid,
    input  wire logic [PORTS-1:0][MASTER_W-1:0] acc_master,
    input  wire logic [PORTS-1:0]            acc_super,
    input  wire logic [PORTS-1:0]            acc_instr,
    input  wire logic [PORTS-1:0]            acc_write,
    input  wire logic [PORTS-1:0][ADDR_W-1:0] acc_addr,
    output logic [PORTS-1:0]                 acc_grant,
    output logic [PORTS-1:0]                 acc_block,
    // error capture
    input  wire logic [PORTS-1:0]            err_clear,
    output logic [PORTS-1:0]                 err_flag,
    output logic [PORTS-1:0][MASTER_W-1:0]   err_master,
    output logic [PORTS-1:0]                 err_super,
    output logic [PORTS-1:0]                 err_instr,
    output logic [PORTS-1:0]                 err_write,
    output rmpu_cause_t [PORTS-1:0]          err_cause,
    output logic [PORTS-1:0][ADDR_W-1:0]     err_addr,
    // identification
    output logic [7:0]                       id_revision,
    output logic [7:0]                       id_ports,
    output logic [1:0]                       id_regions
);
    localparam int unsigned HI_W = ADDR_W - GRAN_BITS;
    localparam logic [HI_W-1:0] HI_ONES = '1;

    function automatic logic [$clog2(REGIONS+1)-1:0] count_hits(input logic [REGIONS-1:0] v);
        count_hits = '0;
        for (int i = 0; i < REGIONS; i++) begin
            count_hits = count_hits + {{($clog2(REGIONS+1)-1){1'b0}}, v[i]};
        end
    endfunction

    // descriptor state
    logic [REGIONS-1:0]                     region_on, next_region_on;
    logic [REGIONS-1:0][HI_W-1:0]           begin_hi, next_begin_hi;
    logic [REGIONS-1:0][HI_W-1:0]           last_hi, next_last_hi;
    logic [REGIONS-1:0][NUM_MASTERS-1:0][RIGHTS_W-1:0] rights, next_rights;
    logic                                   zero_locked;

    // only the debugger may edit region zero bounds, enable and debugger rights, so no other master can shut it out
    assign zero_locked = (cfg_region == '0) && (cfg_src_master != DEBUG_MASTER); // R03 R12

    always_comb begin
        next_region_on = region_on;
        next_begin_hi  = begin_hi;
        next_last_hi   = last_hi;
        next_rights    = rights;
        if (cfg_write) begin
            case (cfg_field)
                FIELD_BEGIN: begin
                    if (!zero_locked) begin // R03
                        next_begin_hi[cfg_region] = cfg_wdata[ADDR_W-1:GRAN_BITS]; // R01
                    end
                end
                FIELD_LAST: begin
                    if (!zero_locked) begin // R03
                        next_last_hi[cfg_region] = cfg_wdata[ADDR_W-1:GRAN_BITS]; // R02
                    end
                end
                FIELD_RIGHTS: begin
                    if (!(zero_locked && cfg_master == DEBUG_MASTER)) begin // R03 R04
                        next_rights[cfg_region][cfg_master] = (cfg_master > LAST_FULL_MASTER)
                            ? (cfg_wdata[RIGHTS_W-1:0] & REDUCED_MASK)
                            : cfg_wdata[RIGHTS_W-1:0]; // R07 R08
                    end
                end
                FIELD_ENABLE: begin
                    if (!zero_locked) begin // R12
                        next_region_on[cfg_region] = cfg_wdata[0]; // R06
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            // region zero opens the whole space to the debugger out of reset
            region_on <= {{(REGIONS-1){1'b0}}, 1'b1}; // R12
            begin_hi  <= '0;
            last_hi   <= '0;
            last_hi[0] <= HI_ONES;
            rights    <= '0;
            rights[0][DEBUG_MASTER] <= RIGHTS_FULL;
        end else begin
            region_on <= next_region_on;
            begin_hi  <= next_begin_hi;
            last_hi   <= next_last_hi;
            rights    <= next_rights;
        end
    end

    // per-port checks
    logic [PORTS-1:0]               violation;
    logic [PORTS-1:0][REGIONS-1:0]  hits;
    logic [PORTS-1:0][REGIONS-1:0]  allows;

    genvar p, r;
    generate
        for (p = 0; p < PORTS; p++) begin : g_port
            for (r = 0; r < REGIONS; r++) begin : g_region
                rmpu_region_check #(
                    .ADDR_W (ADDR_W)
                ) u_check (
                    .region_on            (region_on[r]),
                    .region_begin_address ({begin_hi[r], GRAN_ZERO}), // R01
                    .region_last_address  ({last_hi[r], GRAN_ONES}), // R02
                    .rights               (rights[r][acc_master[p]]),
                    .master               (acc_master[p]), // R15
                    .super_mode           (acc_super[p]),
                    .instr                (acc_instr[p]),
                    .write                (acc_write[p]),
                    .addr                 (acc_addr[p]),
                    .hit                  (hits[p][r]),
                    .allow                (allows[p][r])
                );
            end
            assign violation[p] = acc_valid[p] && prot_enable && !(|allows[p]); // R14
            assign acc_grant[p] = acc_valid[p] && !violation[p]; // R05
            assign acc_block[p] = violation[p]; // R14
        end
    endgenerate

    // error capture state
    logic [PORTS-1:0]                next_err_flag;
    logic [PORTS-1:0][MASTER_W-1:0]  next_err_master;
    logic [PORTS-1:0]                next_err_super, next_err_instr, next_err_write;
    rmpu_cause_t [PORTS-1:0]         next_err_cause;
    logic [PORTS-1:0][ADDR_W-1:0]    next_err_addr;

    always_comb begin
        next_err_flag   = err_flag & ~err_clear;
        next_err_master = err_master;
        next_err_super  = err_super;
        next_err_instr  = err_instr;
        next_err_write  = err_write;
        next_err_cause  = err_cause;
        next_err_addr   = err_addr;
        for (int i = 0; i < PORTS; i++) begin
            if (violation[i]) begin
                // a new fault wins over a clear in the same cycle
                next_err_flag[i]   = 1'b1; // R09
                next_err_master[i] = acc_master[i]; // R10
                next_err_super[i]  = acc_super[i];
                next_err_instr[i]  = acc_instr[i];
                next_err_write[i]  = acc_write[i];
                next_err_addr[i]   = acc_addr[i];
                case (count_hits(hits[i]))
                    '0:      next_err_cause[i] = CAUSE_NO_HIT;
                    1:       next_err_cause[i] = CAUSE_SINGLE;
                    default: next_err_cause[i] = CAUSE_OVERLAP;
                endcase
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            err_flag   <= '0;
            err_master <= '0;
            err_super  <= '0;
            err_instr  <= '0;
            err_write  <= '0;
            err_cause  <= {PORTS{CAUSE_NO_HIT}};
            err_addr   <= '0;
        end else begin
            err_flag   <= next_err_flag;
            err_master <= next_err_master;
            err_super  <= next_err_super;
            err_instr  <= next_err_instr;
            err_write  <= next_err_write;
            err_cause  <= next_err_cause;
            err_addr   <= next_err_addr;
        end
    end

    assign id_revision = REVISION; // R13
    assign id_ports    = 8'(PORTS);
    assign id_regions  = (REGIONS > 12) ? REGIONS_16 : ((REGIONS > 8) ? REGIONS_12 : REGIONS_8);

    a_zero_bounds_kept: assert property (@(posedge clk) disable iff (reset) // R03
        (cfg_write && zero_locked && cfg_field inside {FIELD_BEGIN, FIELD_LAST})
        |=> (begin_hi[0] == $past(begin_hi[0])) && (last_hi[0] == $past(last_hi[0])))
        else $error("core changed region zero bounds");
    a_zero_debug_kept: assert property (@(posedge clk) disable iff (reset) // R03
        (cfg_write && zero_locked && cfg_field == FIELD_RIGHTS && cfg_master == DEBUG_MASTER)
        |=> $stable(rights[0][DEBUG_MASTER]))
        else $error("core changed debugger rights in region zero");
    a_zero_other_write: assert property (@(posedge clk) disable iff (reset) // R04
        (cfg_write && zero_locked && cfg_field == FIELD_RIGHTS && cfg_master == CORE_MASTER)
        |=> rights[0][CORE_MASTER] == $past(cfg_wdata[RIGHTS_W-1:0]))
        else $error("core rights write to region zero lost");
    a_off_grants_all: assert property (@(posedge clk) disable iff (reset) // R05
        (!prot_enable && acc_valid[0]) |-> acc_grant[0] && !acc_block[0])
        else $error("access blocked while protection off");
    a_region_disable: assert property (@(posedge clk) disable iff (reset) // R06
        (cfg_write && cfg_field == FIELD_ENABLE && cfg_region != '0 && !cfg_wdata[0])
        |=> !region_on[$past(cfg_region)])
        else $error("region stayed enabled");
    a_err_flag_set: assert property (@(posedge clk) disable iff (reset) // R09
        acc_block[0] |=> err_flag[0] ##1 (err_flag[0] || $past(err_clear[0])))
        else $error("error flag not set on violation");
    a_err_addr_capture: assert property (@(posedge clk) disable iff (reset) // R10
        acc_block[0] |=> (err_addr[0] == $past(acc_addr[0]))
                         && (err_master[0] == $past(acc_master[0])))
        else $error("fault details not captured");
    a_flag_clears: assert property (@(posedge clk) disable iff (reset) // R09
        (err_clear[0] && !acc_block[0]) |=> !err_flag[0])
        else $error("error flag not cleared");
    a_debug_reset_open: assert property (@(posedge clk) disable iff (reset) // R12
        $fell(reset) |-> region_on[0] && rights[0][DEBUG_MASTER] == RIGHTS_FULL)
        else $error("region zero not open to debugger");
endmodule // region_memory_protection_unit
`default_nettype wire

// ===== rmpu_bus_masters.sv
`timescale 1ns/100ps
`default_nettype none
module rmpu_bus_masters
    import rmpu_pkg::*;
#(
    parameter int unsigned PORTS  = 5,
    parameter int unsigned ADDR_W = 32
) (
    // one request per slave port
    output var logic [PORTS-1:0]               acc_valid,
    output var logic [PORTS-1:0][MASTER_W-1:0] acc_master,
    output var logic [PORTS-1:0]               acc_super,
    output var logic [PORTS-1:0]               acc_instr,
    output var logic [PORTS-1:0]               acc_write,
    output var logic [PORTS-1:0][ADDR_W-1:0]   acc_addr
);
    initial begin
        acc_valid = '0;
        acc_master = '0;
        acc_super = '0;
        acc_instr = '0;
        acc_write = '0;
        acc_addr = '0;
    end
    task automatic drive(input int p, input logic [2:0] m, input logic s, input logic i,
                         input logic w, input logic [ADDR_W-1:0] a);
        acc_valid[p] <= 1'b1;
        acc_master[p] <= m;
        acc_super[p] <= s;
        acc_instr[p] <= i;
        acc_write[p] <= w;
        acc_addr[p] <= a;
    endtask
    // released lines show the inverse, so a stale value never passes for a live one
    task automatic idle(input int p);
        acc_valid[p] <= 1'b0;
        acc_master[p] <= ~acc_master[p];
        acc_super[p] <= ~acc_super[p];
        acc_instr[p] <= ~acc_instr[p];
        acc_write[p] <= ~acc_write[p];
        acc_addr[p] <= ~acc_addr[p];
    endtask
endmodule // rmpu_bus_masters
`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import rmpu_pkg::*;
    localparam int unsigned P   = 5;
    localparam logic [7:0]  REV = 8'h01; // arbitrary value
    logic                 clk = 1'b0;
    logic                 reset = 1'b1;
    logic                 prot_enable = 1'b1;
    logic                 cfg_write = 1'b0;
    logic [2:0]           cfg_src_master = 3'h0;
    logic [2:0]           cfg_region = 3'h0;
    rmpu_field_t          cfg_field = FIELD_BEGIN;
    logic [2:0]           cfg_master = 3'h0;
    logic [31:0]          cfg_wdata = 32'h0;
    logic [P-1:0]         err_clear = '0;
    wire logic [P-1:0]    acc_valid, acc_super, acc_instr, acc_write;
    wire logic [P-1:0][2:0]  acc_master;
    wire logic [P-1:0][31:0] acc_addr;
    logic [P-1:0]         acc_grant, acc_block, err_flag, err_super, err_instr, err_write;
    logic [P-1:0][2:0]    err_master;
    rmpu_cause_t [P-1:0]  err_cause;
    logic [P-1:0][31:0]   err_addr;
    logic [7:0]           id_revision, id_ports;
    logic [1:0]           id_regions;
    logic [31:0]          bg [8], ls [8], rnd;
    logic                 en [8], ef [P], exp_ok;
    logic [4:0]           rt [8][8];
    int                   hits, fails = 0, check_count = 0, cycles = 0, seed = 71;

    always #2 clk = ~clk;

    rmpu_bus_masters #(.PORTS(P), .ADDR_W(32)) bm (.acc_valid(acc_valid),
        .acc_master(acc_master), .acc_super(acc_super), .acc_instr(acc_instr),
        .acc_write(acc_write), .acc_addr(acc_addr));

    region_memory_protection_unit #(.ADDR_W(32), .REGIONS(8), .PORTS(P), .REVISION(REV)) dut (
        .clk(clk), .reset(reset), .prot_enable(prot_enable), .cfg_write(cfg_write),
        .cfg_src_master(cfg_src_master), .cfg_region(cfg_region), .cfg_field(cfg_field),
        .cfg_master(cfg_master), .cfg_wdata(cfg_wdata), .acc_valid(acc_valid),
        .acc_master(acc_master), .acc_super(acc_super), .acc_instr(acc_instr),
        .acc_write(acc_write), .acc_addr(acc_addr), .acc_grant(acc_grant),
        .acc_block(acc_block), .err_clear(err_clear), .err_flag(err_flag),
        .err_master(err_master), .err_super(err_super), .err_instr(err_instr),
        .err_write(err_write), .err_cause(err_cause), .err_addr(err_addr),
        .id_revision(id_revision), .id_ports(id_ports), .id_regions(id_regions));

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 12000) begin
            fails++;
            report_and_stop();
        end
    end

    task automatic cmp_bit(input logic got, input logic exp, input string what);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: %s got %b want %b", $time, what, got, exp);
        end
    endtask

    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    function automatic logic rok(logic [4:0] r, logic [2:0] m, logic s, logic i, logic w);
        logic [2:0] u;
        if (m > LAST_FULL_MASTER)
            return (i || !w) ? r[RED_R_BIT] : r[RED_W_BIT];
        u = r[2:0];
        if (s && r[4:3] != SUP_USER)
            u = (r[4:3] == SUP_RWX) ? 3'h7 : (r[4:3] == SUP_RX) ? 3'h5 : 3'h6;
        return i ? u[USR_X_BIT] : (w ? u[USR_W_BIT] : u[USR_R_BIT]);
    endfunction

    // grants when any enabled region covering the address allows it
    task automatic predict(input logic [2:0] m, input logic s, input logic i, input logic w,
                           input logic [31:0] a);
        hits = 0;
        exp_ok = 1'b0;
        for (int r = 0; r < 8; r++)
            if (en[r] && a >= (bg[r] & ~32'h1F) && a <= (ls[r] | 32'h1F)) begin
                hits++;
                exp_ok |= rok(rt[r][m], m, s, i, w);
            end
    endtask

    task automatic cfg(input logic [2:0] src, input logic [2:0] r, input rmpu_field_t f,
                       input logic [2:0] m, input logic [31:0] d);
        @(posedge clk);
        cfg_write <= 1'b1;
        cfg_src_master <= src;
        cfg_region <= r;
        cfg_field <= f;
        cfg_master <= m;
        cfg_wdata <= d;
        @(posedge clk);
        cfg_write <= 1'b0;
        if (!(src != DEBUG_MASTER && r == 0 && (f != FIELD_RIGHTS || m == DEBUG_MASTER)))
            case (f)
                FIELD_BEGIN: bg[r] = d;
                FIELD_LAST: ls[r] = d;
                FIELD_RIGHTS: rt[r][m] = (m > LAST_FULL_MASTER) ? d[4:0] & REDUCED_MASK : d[4:0];
                default: en[r] = d[0];
            endcase
    endtask

    task automatic access(input int p, input logic [2:0] m, input logic s, input logic i,
                          input logic w, input logic [31:0] a, input logic clr);
        logic viol;
        predict(m, s, i, w, a);
        @(posedge clk);
        // read the enable only once any pending change to it has landed
        viol = prot_enable && !exp_ok;
        bm.drive(p, m, s, i, w, a);
        err_clear[p] <= clr;
        @(negedge clk);
        cmp_bit(acc_grant[p], !viol, "grant");
        cmp_bit(acc_block[p], viol, "block");
        @(posedge clk);
        bm.idle(p);
        err_clear[p] <= 1'b0;
        @(negedge clk);
        // a violation wins over a clear in the same cycle
        ef[p] = viol ? 1'b1 : (clr ? 1'b0 : ef[p]);
        cmp_bit(err_flag[p], ef[p], "flag");
        if (viol) begin
            cmp_word(err_addr[p], a, "addr");
            cmp_word(32'({err_master[p], err_super[p], err_instr[p], err_write[p]}),
                     32'({m, s, i, w}), "attr");
            cmp_word(32'(err_cause[p]), (hits == 0) ? 32'(CAUSE_NO_HIT) : (hits == 1) ?
                     32'(CAUSE_SINGLE) : 32'(CAUSE_OVERLAP), "cause");
        end
    endtask

    initial begin
        for (int r = 0; r < 8; r++) begin
            bg[r] = 32'h0;
            ls[r] = (r == 0) ? 32'hFFFF_FFFF : 32'h0;
            en[r] = (r == 0);
            for (int m = 0; m < 8; m++)
                rt[r][m] = (r == 0 && m == 1) ? RIGHTS_FULL : RIGHTS_NONE;
        end
        for (int p = 0; p < P; p++)
            ef[p] = 1'b0;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        @(negedge clk);
        cmp_word(32'(id_ports), P, "ports");
        cmp_word(32'(id_regions), 32'(REGIONS_8), "regions");
        cmp_word(32'(id_revision), 32'(REV), "revision");
        cfg(CORE_MASTER, 3'h0, FIELD_BEGIN, 3'h0, 32'h0000_1000);
        cfg(CORE_MASTER, 3'h0, FIELD_LAST, 3'h0, 32'h0000_2000);
        cfg(CORE_MASTER, 3'h0, FIELD_RIGHTS, DEBUG_MASTER, 32'h0);
        cfg(CORE_MASTER, 3'h0, FIELD_RIGHTS, 3'h2, 32'h04);
        access(0, DEBUG_MASTER, 1'b1, 1'b0, 1'b1, 32'hFFFF_FFF0, 1'b0);
        access(1, 3'h2, 1'b0, 1'b0, 1'b0, 32'h0000_8000, 1'b0);
        access(1, 3'h2, 1'b0, 1'b0, 1'b1, 32'h0000_8000, 1'b1);
        access(1, 3'h2, 1'b0, 1'b0, 1'b0, 32'h0000_8000, 1'b1);
        cfg(DEBUG_MASTER, 3'h1, FIELD_BEGIN, 3'h0, 32'h0000_201F);
        cfg(DEBUG_MASTER, 3'h1, FIELD_LAST, 3'h0, 32'h0000_2040);
        cfg(DEBUG_MASTER, 3'h1, FIELD_ENABLE, 3'h0, 32'h1);
        cfg(DEBUG_MASTER, 3'h2, FIELD_BEGIN, 3'h0, 32'h0000_2040);
        cfg(DEBUG_MASTER, 3'h2, FIELD_LAST, 3'h0, 32'h0000_2040);
        cfg(DEBUG_MASTER, 3'h2, FIELD_ENABLE, 3'h0, 32'h1);
        for (int c = 0; c < 32; c++) begin
            cfg(DEBUG_MASTER, 3'h1, FIELD_RIGHTS, 3'h3, 32'(c));
            cfg(DEBUG_MASTER, 3'h1, FIELD_RIGHTS, 3'h6, 32'(c));
            for (int k = 0; k < 12; k++)
                access(k % P, (k < 6) ? 3'h3 : 3'h6, (k / 3) % 2 == 1, k % 3 == 2, k % 3 == 1,
                       (k % 4 == 0) ? 32'h0000_2000 : (k % 4 == 1) ? 32'h0000_205F :
                       (k % 4 == 2) ? 32'h0000_1FFF : 32'h0000_2060, 1'b0);
        end
        cfg(CORE_MASTER, 3'h1, FIELD_ENABLE, 3'h0, 32'h0);
        access(2, 3'h3, 1'b0, 1'b0, 1'b0, 32'h0000_2010, 1'b0);
        @(posedge clk);
        prot_enable <= 1'b0;
        access(2, 3'h3, 1'b0, 1'b0, 1'b0, 32'h0000_2010, 1'b0);
        @(posedge clk);
        prot_enable <= 1'b1;
        for (int n = 0; n < 400; n++) begin
            rnd = $random(seed);
            if (rnd[1:0] == 2'h0)
                cfg(rnd[4:2], rnd[7:5], rmpu_field_t'(rnd[9:8]), rnd[12:10],
                    32'($random(seed)) & 32'h0000_3FFF);
            else
                access(32'(rnd[30:28]) % P, rnd[4:2], rnd[5], rnd[6], rnd[7] & !rnd[6],
                       32'($random(seed)) & 32'h0000_3FFF, rnd[8] & rnd[9]);
            if (rnd[15:11] == 5'h0) begin
                @(posedge clk);
                prot_enable <= ~prot_enable;
            end
        end
        report_and_stop();
    end
endmodule // tb_top
`default_nettype wire
